/* common/csed_pkg.sv */
// package: error codes, groups, register map and field layout for the error detector
package csed_pkg;

   // ---------------------------------------------------------------
   // error groups and codes
   // ---------------------------------------------------------------
   localparam logic [3:0] GRP_CFG          = 4'h5;
   localparam logic [3:0] GRP_QUAD         = 4'h6;
   localparam logic [3:0] GRP_LINK         = 4'h7;
   localparam logic [7:0] CODE_MASK_CFG    = 8'h50;
   localparam logic [7:0] CODE_PORT_CFG    = 8'h53;
   localparam logic [7:0] CODE_FORCE_LOCAL = 8'h54;
   localparam logic [7:0] CODE_RT_READ     = 8'h55;
   localparam logic [7:0] CODE_MC_XLATE    = 8'h56;
   localparam logic [7:0] CODE_SYNC_LOST0  = 8'h60;
   localparam logic [7:0] CODE_ALIGN_LOST  = 8'h64;
   localparam logic [7:0] CODE_BAD_CHAR    = 8'h70;
   localparam logic [7:0] CODE_UNALIGNED   = 8'h71;
   localparam logic [7:0] CODE_BAD_ACKID   = 8'h72;

   // ---------------------------------------------------------------
   // route values and sizes
   // ---------------------------------------------------------------
   localparam int         NUM_PORTS        = 10;
   localparam int         NUM_MASKS        = 40;
   localparam int         NUM_LANES        = 4;
   localparam int         NUM_EV           = 16;
   localparam logic [7:0] RT_MASK_BASE     = 8'h40;
   localparam logic [7:0] RT_FORCE_LOCAL   = 8'hdd;
   localparam logic [7:0] RT_NO_ROUTE      = 8'hdf;
   localparam logic [7:0] RT_READ_FAIL     = 8'hff;

   // ---------------------------------------------------------------
   // register map (byte offsets) and field positions
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_ENABLE       = 8'h00;
   localparam logic [7:0] REG_ROUTE_WR     = 8'h04;
   localparam logic [7:0] REG_DOMAIN_WR    = 8'h08;
   localparam logic [7:0] REG_MASK_PORT    = 8'h0c;
   localparam logic [7:0] REG_ASSOC_SEL    = 8'h10;
   localparam logic [7:0] REG_ASSOC_OP     = 8'h14;
   localparam logic [7:0] REG_TRACE_PORT   = 8'h18;
   localparam logic [7:0] REG_INGRESS_SET  = 8'h1c;
   localparam logic [7:0] REG_EGRESS_SET   = 8'h20;
   localparam logic [7:0] REG_RT_READ      = 8'h24;
   localparam logic [7:0] REG_PENDING      = 8'h28;
   localparam int         EN_CFG_BIT       = 0;
   localparam int         EN_QUAD_BIT      = 1;
   localparam int         EN_PORT_BIT      = 2;
   localparam int         QUAD_4X_BIT      = 3;
   localparam int         OP_VERIFY_BIT    = 8;
   localparam int         OP_DOMAIN_BIT    = 9;
   localparam logic [2:0] ENABLE_RESET     = 3'h0;
   localparam logic [5:0] SRC_CFG          = 6'h00;
   localparam logic [5:0] SRC_QUAD_BASE    = 6'h20;
   localparam logic [15:0] PORT_VALID      = 16'h03ff;

   typedef enum logic [1:0] {
      CSED_IDLE  = 2'b00,
      CSED_OFFER = 2'b01
   } csed_arb_t;

endpackage

/* verilog/csed_detect.sv */
// error detector for configuration, serdes quad and link layer error groups
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
module csed_detect
   import csed_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic [7:0]  i_rt_value,
   input  wire logic [3:0]  i_sync_lost,
   input  wire logic        i_align_lost,
   input  wire logic [3:0]  i_bad_char,
   input  wire logic [3:0]  i_unaligned,
   input  wire logic [3:0]  i_bad_ackid,
   input  wire logic        i_log_ready,
   output logic [31:0]      o_rdata,
   output logic [7:0]       o_route_wdata,
   output logic             o_route_we,
   output logic [15:0]      o_portset_wdata,
   output logic             o_log_valid,
   output logic [5:0]       o_log_source,
   output logic [7:0]       o_log_code
);

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   function automatic logic is_port(input logic [7:0] v);
      return v < 8'(NUM_PORTS);
   endfunction

   function automatic logic is_mask(input logic [7:0] v);
      return (v >= RT_MASK_BASE) && (v < RT_MASK_BASE + 8'(NUM_MASKS));
   endfunction

   function automatic logic is_mask_range(input logic [7:0] v);
      return v >= RT_MASK_BASE && v < RT_FORCE_LOCAL;
   endfunction

   // ---------------------------------------------------------------
   // synchronisers for the asynchronous serdes/link event pins
   // ---------------------------------------------------------------
   logic [16:0] pin_raw;
   logic [16:0] s1_q;
   logic [16:0] s2_q;
   logic [16:0] s3_q;
   logic [16:0] lvl_q;
   logic [16:0] pin_rise;

   assign pin_raw = {i_align_lost, i_bad_ackid, i_unaligned, i_bad_char, i_sync_lost};

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // accepted level moves only when the second and third stages agree, so a
   // one-cycle glitch on a pin never becomes a logged error
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         lvl_q <= '0;
      end else begin
         lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
      end
   end

   // a pulse on the cycle both stages first agree on a new high level
   assign pin_rise = s2_q & s3_q & ~lvl_q;

   // ---------------------------------------------------------------
   // register bus
   // ---------------------------------------------------------------
   logic [3:0]  enable_q;
   logic [7:0]  rt_sel;
   logic [31:0] rdata_d;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         enable_q <= {1'b0, ENABLE_RESET};
      end else if (i_wr && i_addr == REG_ENABLE) begin
         enable_q <= i_wdata[3:0];
      end
   end

   logic [15:0] pend_q;

   always_comb begin
      rt_sel  = is_port(i_rt_value) || is_mask(i_rt_value) || i_rt_value == RT_NO_ROUTE
                ? i_rt_value : RT_READ_FAIL;
      rdata_d = 32'h0;
      case (i_addr)
         REG_ENABLE:  rdata_d = {28'h0, enable_q};
         REG_RT_READ: rdata_d = {24'h0, rt_sel};
         REG_PENDING: rdata_d = {16'h0, pend_q};
         default:     rdata_d = 32'h0;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_rdata <= 32'h0;
      end else begin
         o_rdata <= i_rd ? rdata_d : 32'h0;
      end
   end

   // ---------------------------------------------------------------
   // route table writes with substitution
   // ---------------------------------------------------------------
   logic [7:0] wv;
   logic       wr_route;
   assign wv       = i_wdata[7:0];
   assign wr_route = i_wr && i_addr == REG_ROUTE_WR;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_route_we    <= 1'b0;
         o_route_wdata <= RT_NO_ROUTE;
      end else begin
         o_route_we    <= wr_route;
         if (wr_route) begin
            o_route_wdata <= (is_port(wv) || is_mask(wv) || wv == RT_NO_ROUTE) ? wv
                             : RT_NO_ROUTE;
         end
      end
   end

   // partial write of valid port bits
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_portset_wdata <= 16'h0;
      end else if (i_wr && (i_addr == REG_INGRESS_SET || i_addr == REG_EGRESS_SET
                            || i_addr == REG_MASK_PORT)) begin
         o_portset_wdata <= i_wdata[15:0] & PORT_VALID;
      end
   end

   // ---------------------------------------------------------------
   // event detection: one slot per source/code pair; slots 11 and 12 share one pair and ackID has no slot
   // ---------------------------------------------------------------
   logic [NUM_EV-1:0] ev;
   logic [7:0]        ev_code [NUM_EV];
   logic [5:0]        ev_src  [NUM_EV];
   logic              bad_rt_read;
   logic              bad_mask_read;

   assign bad_rt_read = i_rd && i_addr == REG_RT_READ && rt_sel == RT_READ_FAIL;
   // a read that lands between the last mask and the local value
   assign bad_mask_read = i_rd && i_addr == REG_RT_READ && is_mask_range(i_rt_value)
                          && !is_mask(i_rt_value);

   always_comb begin
      ev = '0;
      if (enable_q[EN_CFG_BIT] && i_wr) begin
         ev[0] = (i_addr == REG_ROUTE_WR && is_mask_range(wv) && !is_mask(wv))
              || (i_addr == REG_DOMAIN_WR && is_mask_range(wv))
              || (i_addr == REG_MASK_PORT && !is_mask(i_wdata[23:16]))
              || (i_addr == REG_ASSOC_SEL && !is_mask(wv))
              || (i_addr == REG_ASSOC_OP && i_wdata[OP_VERIFY_BIT] && i_wdata[OP_DOMAIN_BIT]);
         ev[1] = (i_addr == REG_ROUTE_WR && !is_mask_range(wv) && !is_port(wv)
                  && wv != RT_FORCE_LOCAL && wv != RT_NO_ROUTE)
              || (i_addr == REG_MASK_PORT && !is_port(i_wdata[7:0]))
              || (i_addr == REG_TRACE_PORT && !is_port(wv));
         ev[2] = i_addr == REG_ROUTE_WR && wv == RT_FORCE_LOCAL;
         ev[4] = (i_addr == REG_INGRESS_SET || i_addr == REG_EGRESS_SET
                  || i_addr == REG_MASK_PORT) && |(i_wdata[15:0] & ~PORT_VALID);
      end
      ev[3] = enable_q[EN_CFG_BIT] && bad_rt_read;
      ev[0] = ev[0] | (enable_q[EN_CFG_BIT] && bad_mask_read);
      if (enable_q[EN_QUAD_BIT]) begin
         ev[8:5] = pin_rise[3:0];
         ev[9]   = pin_rise[16] && enable_q[QUAD_4X_BIT];
      end
      if (enable_q[EN_PORT_BIT]) begin
         ev[10] = |pin_rise[7:4];
         ev[11] = enable_q[QUAD_4X_BIT] && |pin_rise[11:8];
         ev[15:12] = enable_q[QUAD_4X_BIT] ? 4'h0 : pin_rise[11:8];
      end
   end

   generate
      for (genvar k = 0; k < NUM_EV; k++) begin : g_slot
         if (k < 5) begin : g_cfg
            assign ev_src[k]  = SRC_CFG;
            assign ev_code[k] = (k == 0) ? CODE_MASK_CFG : (k == 1) ? CODE_PORT_CFG :
                                (k == 2) ? CODE_FORCE_LOCAL : (k == 3) ? CODE_RT_READ :
                                CODE_MC_XLATE;
         end else if (k < 10) begin : g_quad
            assign ev_src[k]  = SRC_QUAD_BASE;
            assign ev_code[k] = CODE_SYNC_LOST0 + 8'(k - 5);
         end else if (k < 12) begin : g_link
            assign ev_src[k]  = SRC_QUAD_BASE;
            assign ev_code[k] = (k == 10) ? CODE_BAD_CHAR : CODE_UNALIGNED;
         end else begin : g_lane
            assign ev_src[k]  = SRC_QUAD_BASE + 6'(k - 12);
            assign ev_code[k] = CODE_UNALIGNED;
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // pending flags and log hand-off
   // ---------------------------------------------------------------
   logic [NUM_EV-1:0] grant;
   logic [3:0]        pick;
   logic              ackid_ev;
   logic              ackid_pend_q;
   logic [3:0]        pick_q;
   logic              ack_offer_q;
   csed_arb_t         state_q;

   assign ackid_ev = enable_q[EN_PORT_BIT] && |pin_rise[15:12];

   always_comb begin
      pick = 4'h0;
      for (int j = NUM_EV - 1; j >= 0; j--) begin
         if (pend_q[j]) begin
            pick = 4'(j);
         end
      end
   end

   // the slot on offer is remembered, so a lower slot that turns up while an
   // entry waits, or an ackID entry on offer, never clears the wrong flag
   assign grant = (state_q == CSED_OFFER && i_log_ready && !ack_offer_q) ? (16'h1 << pick_q)
                  : 16'h0;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         pend_q <= '0;
      end else begin
         pend_q <= (pend_q & ~grant) | ev;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         ackid_pend_q <= 1'b0;
      end else begin
         ackid_pend_q <= ackid_ev | (ackid_pend_q & ~(state_q == CSED_IDLE));
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_q      <= CSED_IDLE;
         pick_q       <= 4'h0;
         ack_offer_q  <= 1'b0;
         o_log_valid  <= 1'b0;
         o_log_source <= 6'h0;
         o_log_code   <= 8'h0;
      end else begin
         case (state_q)
            CSED_IDLE: begin
               if (ackid_pend_q) begin
                  o_log_valid  <= 1'b1;
                  o_log_source <= SRC_QUAD_BASE;
                  o_log_code   <= CODE_BAD_ACKID;
                  ack_offer_q  <= 1'b1;
                  state_q      <= CSED_OFFER;
               end else if (|pend_q) begin
                  o_log_valid  <= 1'b1;
                  o_log_source <= ev_src[pick];
                  o_log_code   <= ev_code[pick];
                  pick_q       <= pick;
                  ack_offer_q  <= 1'b0;
                  state_q      <= CSED_OFFER;
               end
            end
            CSED_OFFER: begin
               if (i_log_ready) begin
                  o_log_valid <= 1'b0;
                  state_q     <= CSED_IDLE;
               end
            end
            default: state_q <= CSED_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_cfg_gate: assert property (@(posedge i_clk) disable iff (i_reset)
      !enable_q[EN_CFG_BIT] |-> ev[4:0] == 5'h0) else $error("config event while disabled");
   a_route_sub: assert property (@(posedge i_clk) disable iff (i_reset)
      (wr_route && wv == RT_FORCE_LOCAL) |=> o_route_we && o_route_wdata == RT_NO_ROUTE)
      else $error("local value not replaced");
   a_rd_fail: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_rd && i_addr == REG_RT_READ && !is_port(i_rt_value) && !is_mask(i_rt_value)
       && i_rt_value != RT_NO_ROUTE) |=> o_rdata == {24'h0, RT_READ_FAIL})
      else $error("illegal read not ff");
   a_partial_wr: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_wr && i_addr == REG_INGRESS_SET) |=> o_portset_wdata == ($past(i_wdata[15:0]) & PORT_VALID))
      else $error("port set write wrong");
   a_quad_gate: assert property (@(posedge i_clk) disable iff (i_reset)
      !enable_q[EN_QUAD_BIT] |-> ev[9:5] == 5'h0) else $error("quad event while disabled");
   a_link_gate: assert property (@(posedge i_clk) disable iff (i_reset)
      !enable_q[EN_PORT_BIT] |-> ev[15:10] == 6'h0 && !ackid_ev)
      else $error("link event while disabled");
   a_sync_code: assert property (@(posedge i_clk) disable iff (i_reset)
      (o_log_valid && o_log_code >= CODE_SYNC_LOST0 && o_log_code < CODE_ALIGN_LOST)
      |-> o_log_source == SRC_QUAD_BASE) else $error("sync code source wrong");
   a_hold_entry: assert property (@(posedge i_clk) disable iff (i_reset)
      (o_log_valid && !i_log_ready) |=> o_log_valid && $stable(o_log_code))
      else $error("entry dropped before accept");
   a_offer_bound: assert property (@(posedge i_clk) disable iff (i_reset)
      (|pend_q && state_q == CSED_IDLE) |=> o_log_valid) else $error("pending not offered");
   // the offered slot stays pending until the log takes it
   a_offer_live: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_q == CSED_OFFER && !ack_offer_q) |-> pend_q[pick_q])
      else $error("offered slot not pending");
   a_ack_no_drop: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_q == CSED_OFFER && ack_offer_q) |=> (($past(pend_q) & ~pend_q) == 16'h0))
      else $error("flag cleared under ackID entry");
   a_read_code: assert property (@(posedge i_clk) disable iff (i_reset)
      (enable_q[EN_CFG_BIT] && bad_rt_read) |=> pend_q[3])
      else $error("illegal read not pending");

   c_cfg_log:  cover property (@(posedge i_clk) o_log_valid && o_log_code == CODE_MASK_CFG);
   c_quad_log: cover property (@(posedge i_clk) o_log_valid && o_log_code == CODE_ALIGN_LOST);
   c_ack_log:  cover property (@(posedge i_clk) o_log_valid && o_log_code == CODE_BAD_ACKID);
   c_backlog:  cover property (@(posedge i_clk) $countones(pend_q) > 1);

endmodule // csed_detect

/* test/csed_tb.sv */
// self-checking testbench for the configuration, serdes and link error detector
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_errors++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb;
   import csed_pkg::*;
   typedef struct {logic [5:0] src; logic [7:0] code; bit any_src;} csed_note_t;
   localparam int LIMIT = 20000;
   logic        i_clk = 1'b0;
   logic        i_reset = 1'b1;
   logic [7:0]  i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [7:0]  i_rt_value = 8'h00;
   logic [3:0]  i_sync_lost = 4'h0;
   logic        i_align_lost = 1'b0;
   logic [3:0]  i_bad_char = 4'h0;
   logic [3:0]  i_unaligned = 4'h0;
   logic [3:0]  i_bad_ackid = 4'h0;
   logic        i_log_ready = 1'b0;
   logic [31:0] o_rdata;
   logic [7:0]  o_route_wdata;
   logic        o_route_we;
   logic [15:0] o_portset_wdata;
   logic        o_log_valid;
   logic [5:0]  o_log_source;
   logic [7:0]  o_log_code;
   int          n_errors = 0;
   int          total_checks = 0;
   int          cycles = 0;
   logic [31:0] rnd = 32'h9809;
   csed_note_t  notes[$];
   csed_note_t  nt;
   // config table: address, data, code (00 = none), expected port set (checked for the last two entries)
   logic [7:0]  ta[12] = '{REG_DOMAIN_WR, REG_DOMAIN_WR, REG_MASK_PORT, REG_MASK_PORT,
                           REG_MASK_PORT, REG_ASSOC_SEL, REG_ASSOC_SEL, REG_ASSOC_OP,
                           REG_ASSOC_OP, REG_TRACE_PORT, REG_INGRESS_SET, REG_EGRESS_SET};
   logic [31:0] td[12] = '{32'h40, 32'h05, 32'h680001, 32'h40000a, 32'h408001, 32'h68,
                           32'h41, 32'h300, 32'h100, 32'h0a, 32'h0400, 32'hffff};
   logic [7:0]  tc[12] = '{8'h50, 8'h00, 8'h50, 8'h53, 8'h56, 8'h50, 8'h00, 8'h50,
                           8'h00, 8'h53, 8'h56, 8'h56};
   logic [15:0] tp[12] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
                           16'h0, 16'h0, 16'h0000, 16'h03ff};

   csed_detect dut_u (
      .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .i_rt_value(i_rt_value), .i_sync_lost(i_sync_lost),
      .i_align_lost(i_align_lost), .i_bad_char(i_bad_char), .i_unaligned(i_unaligned),
      .i_bad_ackid(i_bad_ackid), .i_log_ready(i_log_ready), .o_rdata(o_rdata),
      .o_route_wdata(o_route_wdata), .o_route_we(o_route_we),
      .o_portset_wdata(o_portset_wdata), .o_log_valid(o_log_valid),
      .o_log_source(o_log_source), .o_log_code(o_log_code)
   );

   always #4 i_clk = ~i_clk;

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic note(input logic [5:0] s, input logic [7:0] c, input bit any);
      notes.push_back('{s, c, any});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [31:0] ex);
      @(posedge i_clk);
      i_addr     <= a;
      i_rt_value <= v;
      i_rd       <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      `CHK("read data", ex, o_rdata)
   endtask

   task automatic drain(input string nm);
      int k;
      k = 0;
      while (notes.size() != 0 && k < 300) begin
         @(posedge i_clk);
         k++;
      end
      `CHK("pending entries", 0, notes.size())
      repeat (8) @(posedge i_clk);
      $display("test %s done", nm);
   endtask

   task automatic route(input logic [7:0] v, input logic [7:0] ex, input logic [7:0] c);
      if (c != 8'h00) note(SRC_CFG, c, 1'b0);
      wr(REG_ROUTE_WR, {24'h0, v});
      `CHK("route strobe", 1'b1, o_route_we)
      `CHK("route value", ex, o_route_wdata)
      drain("route write");
   endtask

   // pin events are levels held a few cycles, the block reacts to the rise
   task automatic pins(input int sel, input logic [3:0] v);
      @(posedge i_clk);
      case (sel)
         0: i_sync_lost <= v;
         1: i_align_lost <= v[0];
         2: i_bad_char <= v;
         3: i_unaligned <= v;
         default: i_bad_ackid <= v;
      endcase
      repeat (3) @(posedge i_clk);
      i_sync_lost  <= 4'h0;
      i_align_lost <= 1'b0;
      i_bad_char   <= 4'h0;
      i_unaligned  <= 4'h0;
      i_bad_ackid  <= 4'h0;
      drain("pin event");
   endtask

   // --------------------------------------------------------------
   // log watcher: random stalls on ready, oldest note compared first
   // --------------------------------------------------------------
   always @(posedge i_clk) begin
      cycles++;
      if (i_reset === 1'b0 && o_log_valid === 1'b1 && i_log_ready === 1'b1) begin
         if (notes.size() == 0) begin
            total_checks++;
            n_errors++;
            $display("unexpected log entry expected none seen %h", o_log_code);
         end else begin
            nt = notes.pop_front();
            `CHK("log code", nt.code, o_log_code)
            if (!nt.any_src) `CHK("log source", nt.src, o_log_source)
         end
      end
      rnd = xs(rnd);
      i_log_ready <= rnd[0] | rnd[1];
      if (cycles == LIMIT) begin
         n_errors++;
         $display("unexpected timeout expected %0d seen %0d", LIMIT, cycles);
         test_done();
      end
   end

   initial begin
      repeat (6) @(posedge i_clk);
      i_reset <= 1'b0;
      #1;
      `CHK("reset route value", RT_NO_ROUTE, o_route_wdata)
      `CHK("reset log valid", 1'b0, o_log_valid)
      rd(REG_ENABLE, 8'h00, 32'h0);
      rd(8'h3c, 8'h00, 32'h0);
      // enables cleared: no config entries
      route(8'hdd, RT_NO_ROUTE, 8'h00);
      wr(REG_TRACE_PORT, 32'h0a);
      drain("config disabled");
      wr(REG_ENABLE, 32'h1);
      route(8'h09, 8'h09, 8'h00);
      route(8'h0a, RT_NO_ROUTE, CODE_PORT_CFG);
      route(8'h67, 8'h67, 8'h00);
      route(8'h68, RT_NO_ROUTE, CODE_MASK_CFG);
      route(8'h3f, RT_NO_ROUTE, CODE_PORT_CFG);
      route(RT_FORCE_LOCAL, RT_NO_ROUTE, CODE_FORCE_LOCAL);
      route(8'(rnd % 10), 8'(rnd % 10), 8'h00);
      for (int i = 0; i < 12; i++) begin
         if (tc[i] != 8'h00) note(SRC_CFG, tc[i], 1'b0);
         wr(ta[i], td[i]);
         if (i >= 10) `CHK("port set value", tp[i], o_portset_wdata)
         drain("config register");
      end
      rd(REG_RT_READ, 8'h05, 32'h05);
      note(SRC_CFG, CODE_RT_READ, 1'b0);
      rd(REG_RT_READ, 8'h0c, {24'h0, RT_READ_FAIL});
      drain("route read");
      // a value between the last mask and the local value raises both codes
      note(SRC_CFG, CODE_MASK_CFG, 1'b0);
      note(SRC_CFG, CODE_RT_READ, 1'b0);
      rd(REG_RT_READ, 8'h68, {24'h0, RT_READ_FAIL});
      drain("mask read");
      pins(0, 4'hf);
      wr(REG_ENABLE, 32'h2);
      for (int n = 0; n < 4; n++) note(SRC_QUAD_BASE, CODE_SYNC_LOST0 + 8'(n), 1'b0);
      pins(0, 4'hf);
      pins(1, 4'h1);
      wr(REG_ENABLE, 32'ha);
      note(SRC_QUAD_BASE, CODE_ALIGN_LOST, 1'b0);
      pins(1, 4'h1);
      pins(2, 4'h2);
      wr(REG_ENABLE, 32'h4);
      note(SRC_QUAD_BASE, CODE_BAD_CHAR, 1'b0);
      pins(2, 4'h2);
      note(SRC_QUAD_BASE, CODE_BAD_ACKID, 1'b0);
      pins(4, 4'h1);
      note(SRC_QUAD_BASE + 6'h2, CODE_UNALIGNED, 1'b0);
      pins(3, 4'h4);
      wr(REG_ENABLE, 32'hc);
      note(SRC_QUAD_BASE, CODE_UNALIGNED, 1'b0);
      pins(3, 4'h4);
      // a reset in mid-run clears the enables, so a link error stays silent
      @(posedge i_clk);
      i_reset <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_reset <= 1'b0;
      rd(REG_ENABLE, 8'h00, 32'h0);
      pins(2, 4'h2);
      test_done();
   end
endmodule // tb
